// File: rtl/drv_defs.svh
`ifndef DRV_DEFS_SVH
`define DRV_DEFS_SVH
`define WORD_W 16
`define SW_N 8
`define CNT_W 16
`define SEL_BIT 0
`define SW_LSB 1
`define PWM_LSB 1
`define RECOV_LSB 6
`define NR_BIT 10
`define SPARE_BIT 9
`define OLD_BIT 14
`define ONE_BIT 15
`define LEG_N 3
`define FRAME_LEN 5'h10
`define CNT_MAX 5'h1F
`define CLK_MHZ 25
`define OL_FILTER_US 1000
`define STARTUP_US 200
`define RECOV_US 100
`define OL_CYCLES (`OL_FILTER_US * `CLK_MHZ)
`define STARTUP_CYCLES (`STARTUP_US * `CLK_MHZ)
`define RECOV_CYCLES (`RECOV_US * `CLK_MHZ)
`endif

// File: rtl/drv_pkg.sv
`default_nettype none
`include "drv_defs.svh"
package drv_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`SW_N-1:0] sw_vec_t;
  typedef struct packed {
    word_t cfg0;
    word_t cfg1;
    logic sel;
    sw_vec_t oc_m;
    sw_vec_t oc_s;
    sw_vec_t oc;
    sw_vec_t trip;
    sw_vec_t drive;
    logic nr;
    logic [`CNT_W-1:0] nr_cnt;
    logic [`CNT_W-1:0] rec_cnt;
    logic sck_m, sck_s, sck_p;
    logic csn_m, csn_s, csn_p;
    logic sdi_m, sdi_s;
    logic pwm_m, pwm_s;
    logic act_m, act_s, act_p;
    word_t shift_in;
    word_t shift_out;
    logic [4:0] bitcnt;
    logic sdo;
    logic sdo_oe;
    logic ol_clr;
  } main_state_t;
  typedef struct packed {
    sw_vec_t low_m;
    sw_vec_t low_s;
    logic [`SW_N-1:0][`CNT_W-1:0] cnt;
    sw_vec_t flag;
  } ol_state_t;
endpackage
`default_nettype wire

// File: rtl/open_load_if.sv
`timescale 1ns/1ps
`default_nettype none
interface open_load_if;
  logic [7:0] sw_on;
  logic [7:0] low_cur;
  logic [7:0] flag;
  logic clr;
  modport ctrl (output sw_on, output low_cur, output clr, input flag);
  modport mon (input sw_on, input low_cur, input clr, output flag);
endinterface
`default_nettype wire

// File: rtl/open_load_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "drv_defs.svh"
module open_load_filter
  import drv_pkg::*;
#(
  parameter int unsigned OL_CYCLES = `OL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  open_load_if.mon io
);
  localparam logic [`CNT_W-1:0] OL_LAST = `CNT_W'(OL_CYCLES - 1);
  ol_state_t q, d;

  always_comb begin
    d = q;
    d.low_m = io.low_cur;
    d.low_s = q.low_m;
    for (int i = 0; i < `SW_N; i++) begin
      // Any gap in low current or switch-off restarts the filter
      if (io.sw_on[i] && q.low_s[i]) begin
        if (q.cnt[i] != OL_LAST) begin
          d.cnt[i] = q.cnt[i] + 1'b1;
        end
      end else begin
        d.cnt[i] = '0;
      end
      if (io.clr) begin
        d.flag[i] = 1'b0;
      end
      if (io.sw_on[i] && q.low_s[i] && q.cnt[i] == OL_LAST) begin
        d.flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign io.flag = q.flag;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ol_filter_time_a: assert property ($rose(q.flag[6]) |-> $past(q.cnt[6]) == OL_LAST)
    else $error("open-load flag set before filter time");
  ol_needs_on_a: assert property (!io.sw_on[3] && !io.clr |=> q.flag[3] == $past(q.flag[3]))
    else $error("open-load flag changed on idle switch");
  ol_set_cov: cover property ($rose(q.flag[6]));
endmodule
`default_nettype wire

// File: rtl/driver_config_diag_reg1.sv
// Functional notes
// - Overcurrent on a switch sets its status-0 flag and turns that switch off.
// - Config-1 bits 10..6 enable automatic re-enable of tripped outputs after delay.
// - Recovery needs its enable and lands on the shared timer tick, so its delay depends on timer phase.
// - Config-1 bits 5..1 make an enabled output follow the PWM input.
// - Status-1 bit 10 flags start-up after standby exit; outputs held off meanwhile.
// - Status bit 0 is NOR of bits 1..14 of both status words.
// - Open-load disable bit 14 removes open-load flags from that NOR.
// - Status-1 bit 15 always reads one.
// - Both switches of one half bridge never conduct together.
`timescale 1ns/1ps
`default_nettype none
`include "drv_defs.svh"
module driver_config_diag_reg1
  import drv_pkg::*;
#(
  parameter int unsigned OL_CYCLES = `OL_CYCLES,
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter int unsigned RECOV_CYCLES = `RECOV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_clk,
  input wire logic chip_sel_n,
  input wire logic spi_din,
  output logic spi_dout,
  output logic spi_dout_oe,
  input wire logic pwm_in,
  input wire logic active_mode,
  input wire logic [7:0] overcurrent,
  input wire logic [7:0] low_current,
  output logic [7:0] switch_on
);
  localparam logic [`CNT_W-1:0] NR_LAST = `CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [`CNT_W-1:0] REC_LAST = `CNT_W'(RECOV_CYCLES - 1);

  main_state_t q, d;
  word_t st0, st1;
  logic rec_tick;
  logic ol_masked;
  open_load_if ol_io ();

  assign ol_io.sw_on = q.drive;
  assign ol_io.low_cur = low_current;
  assign ol_io.clr = q.ol_clr;

  open_load_filter #(
    .OL_CYCLES(OL_CYCLES)
  ) u_ol (
    .clk(clk),
    .rst(rst),
    .io(ol_io)
  );

  // One shared recovery timer keeps area low; recovery lands on its phase
  assign rec_tick = (q.rec_cnt == REC_LAST);
  assign ol_masked = q.cfg0[`OLD_BIT] ? 1'b0 : (|ol_io.flag);

  always_comb begin
    st0 = '0;
    st0[`SW_LSB +: `SW_N] = q.oc;
    st1 = '0;
    st1[`ONE_BIT] = 1'b1;
    st1[`SPARE_BIT] = 1'b0;
    st1[`NR_BIT] = q.nr;
    st1[`SW_LSB +: `SW_N] = ol_io.flag;
    st0[0] = ~((|q.oc) | q.nr | ol_masked);
    st1[0] = st0[0];
  end

  always_comb begin
    logic sck_rise, sck_fall, csn_fall, csn_rise;
    logic [7:0] want;
    int o;
    sck_rise = q.sck_s & ~q.sck_p;
    sck_fall = ~q.sck_s & q.sck_p;
    csn_fall = ~q.csn_s & q.csn_p;
    csn_rise = q.csn_s & ~q.csn_p;
    want = '0;
    o = 0;
    d = q;
    d.ol_clr = 1'b0;
    d.sck_m = spi_clk;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.csn_m = chip_sel_n;
    d.csn_s = q.csn_m;
    d.csn_p = q.csn_s;
    d.sdi_m = spi_din;
    d.sdi_s = q.sdi_m;
    d.pwm_m = pwm_in;
    d.pwm_s = q.pwm_m;
    d.act_m = active_mode;
    d.act_s = q.act_m;
    d.act_p = q.act_s;
    d.oc_m = overcurrent;
    d.oc_s = q.oc_m;

    // Serial frame: status shifted out MSB first, command shifted in
    if (csn_fall) begin
      d.shift_out = q.sel ? st1 : st0;
      d.sdo = q.sel ? st1[`WORD_W-1] : st0[`WORD_W-1];
      d.sdo_oe = 1'b1;
      d.bitcnt = '0;
    end else if (!q.csn_s) begin
      if (sck_rise) begin
        d.shift_in = {q.shift_in[`WORD_W-2:0], q.sdi_s};
        if (q.bitcnt != `CNT_MAX) begin
          d.bitcnt = q.bitcnt + 1'b1;
        end
      end
      if (sck_fall) begin
        d.shift_out = {q.shift_out[`WORD_W-2:0], 1'b0};
        d.sdo = q.shift_out[`WORD_W-2];
      end
    end
    if (csn_rise) begin
      d.sdo_oe = 1'b0;
      // Frames of any other length are dropped whole
      if (q.bitcnt == `FRAME_LEN) begin
        d.sel = q.shift_in[`SEL_BIT];
        if (q.shift_in[`SEL_BIT]) begin
          d.cfg1 = q.shift_in;
        end else begin
          d.cfg0 = q.shift_in;
          d.oc = '0;
          d.trip = '0;
          d.ol_clr = 1'b1;
        end
      end
    end

    // Start-up timer after leaving standby
    if (q.act_s && !q.act_p) begin
      d.nr = 1'b1;
      d.nr_cnt = '0;
    end else if (q.nr) begin
      if (q.nr_cnt == NR_LAST) begin
        d.nr = 1'b0;
      end else begin
        d.nr_cnt = q.nr_cnt + 1'b1;
      end
    end

    d.rec_cnt = rec_tick ? '0 : q.rec_cnt + 1'b1;
    for (int i = 0; i < `SW_N; i++) begin
      o = (i < 2 * `LEG_N) ? i / 2 : i - `LEG_N;
      if (rec_tick && q.cfg1[`RECOV_LSB + o]) begin
        d.trip[i] = 1'b0;
      end
      // Trip set wins over a clearing write in the same cycle
      if (q.oc_s[i] && q.drive[i]) begin
        d.oc[i] = 1'b1;
        d.trip[i] = 1'b1;
      end
      // Two synced active samples, so not-ready is up before any switch can follow
      want[i] = q.cfg0[`SW_LSB + i] & ~q.trip[i] & ~q.nr & q.act_s & q.act_p;
      if (q.cfg1[`PWM_LSB + o]) begin
        want[i] = want[i] & q.pwm_s;
      end
    end
    d.drive = want & ~(q.oc_s & q.drive);
    for (int k = 0; k < `LEG_N; k++) begin
      // Both bits set means neither switch; opposite switch must be off first
      if (q.cfg0[`SW_LSB + 2 * k] && q.cfg0[`SW_LSB + 2 * k + 1]) begin
        d.drive[2 * k] = 1'b0;
        d.drive[2 * k + 1] = 1'b0;
      end
      if (q.drive[2 * k]) begin
        d.drive[2 * k + 1] = 1'b0;
      end
      if (q.drive[2 * k + 1]) begin
        d.drive[2 * k] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign switch_on = q.drive;
  assign spi_dout = q.sdo;
  assign spi_dout_oe = q.sdo_oe;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  leg_exclusive_a: assert property (!(switch_on[0] && switch_on[1]) &&
    !(switch_on[2] && switch_on[3]) && !(switch_on[4] && switch_on[5]))
    else $error("half bridge has both switches on");
  oc_trip_a: assert property ((q.oc_s & q.drive) != 8'h00 |=>
    (($past(q.oc_s & q.drive) & ~q.oc) == 8'h00) && ((q.drive & $past(q.oc_s)) == 8'h00))
    else $error("overcurrent did not set flag and switch off");
  trip_recover_a: assert property (q.trip[6] && q.cfg1[9] && rec_tick |=> !q.trip[6])
    else $error("enabled recovery did not release output");
  pwm_gate_a: assert property (q.cfg1[`PWM_LSB + 3] && !q.pwm_s |=> !switch_on[6])
    else $error("gated output on while pwm low");
  nr_timer_a: assert property ($fell(q.nr) |-> $past(q.nr_cnt) == NR_LAST)
    else $error("not-ready cleared at wrong time");
  nr_block_a: assert property (q.nr |-> switch_on == 8'h00)
    else $error("output active during start-up");
  no_error_a: assert property ((q.oc != 8'h00 || q.nr) |-> !st0[0] && !st1[0])
    else $error("no-error bit high with error present");
  ol_ignore_a: assert property (q.cfg0[`OLD_BIT] && q.oc == 8'h00 && !q.nr |-> st0[0])
    else $error("open-load not ignored when disabled");
  fixed_bits_a: assert property (st1[15] && !st1[9])
    else $error("fixed status bits wrong");

  trip_cov: cover property ((q.oc_s & q.drive) != 8'h00);
  startup_cov: cover property ($fell(q.nr));
  cfg1_write_cov: cover property ($rose(q.csn_s) && q.bitcnt == `FRAME_LEN && q.shift_in[0]);
  recover_cov: cover property ($fell(q.trip[6]) && q.oc[6]);
endmodule
`default_nettype wire

// File: tb/spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host
  import drv_pkg::*;
(
  input wire logic clk,
  input wire logic spi_dout,
  output logic spi_clk,
  output logic chip_sel_n,
  output logic spi_din
);
  initial begin
    spi_clk = 1'b0;
    chip_sel_n = 1'b1;
    spi_din = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Mode 0, four clk per half period; reply bit read one and a half clk after the rise
  task automatic xfer(input word_t tx, output word_t rx);
    @(posedge clk);
    chip_sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_din <= tx[i];
      wait_clk(4);
      spi_clk <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      rx[i] = spi_dout;
      wait_clk(3);
      spi_clk <= 1'b0;
    end
    wait_clk(4);
    chip_sel_n <= 1'b1;
    // Idle data flipped so a stale bit is never mistaken for a live one
    spi_din <= ~tx[0];
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_driver_config_diag_reg1.sv
`timescale 1ns/1ps
`default_nettype none
module tb_driver_config_diag_reg1
  import drv_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwm_in = 1'b0;
  logic active_mode = 1'b0;
  logic [7:0] overcurrent = 8'h00;
  logic [7:0] low_current = 8'h00;
  logic [7:0] switch_on;
  wire spi_clk;
  wire chip_sel_n;
  wire spi_din;
  wire spi_dout;
  wire spi_dout_oe;
  wire sdo_line;
  word_t rx;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  // A released data line shows the inverse, so a late enable corrupts the reply
  assign sdo_line = spi_dout_oe ? spi_dout : ~spi_dout;
  driver_config_diag_reg1 #(.OL_CYCLES(20), .STARTUP_CYCLES(200), .RECOV_CYCLES(16))
    driver_config_diag_reg1_i (.clk(clk), .rst(rst), .spi_clk(spi_clk),
    .chip_sel_n(chip_sel_n), .spi_din(spi_din), .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe), .pwm_in(pwm_in), .active_mode(active_mode),
    .overcurrent(overcurrent), .low_current(low_current), .switch_on(switch_on));
  spi_host spi_host_i (.clk(clk), .spi_dout(sdo_line), .spi_clk(spi_clk),
    .chip_sel_n(chip_sel_n), .spi_din(spi_din));
  task automatic chk(input word_t got, input word_t exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_sw(input logic [7:0] exp);
    chk({8'h00, switch_on}, {8'h00, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic frame(input word_t tx);
    fork
      spi_host_i.xfer(tx, rx);
      begin
        step(10);
        chk({15'h0, spi_dout_oe}, 16'h0001);
      end
    join
    chk({15'h0, spi_dout_oe}, 16'h0000);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic test_startup();
    frame(16'h0001);
    frame(16'h0080);
    frame(16'h0001);
    active_mode <= 1'b1;
    step(6);
    chk_sw(8'h00);
    frame(16'h0001);
    chk(rx, 16'h8400);
    step(200);
    frame(16'h0001);
    chk(rx, 16'h8001);
    chk_sw(8'h40);
    $display("test startup done");
  endtask
  task automatic test_pwm_leg();
    frame(16'h0011);
    pwm_in <= 1'b0;
    step(6);
    chk_sw(8'h00);
    pwm_in <= 1'b1;
    step(6);
    chk_sw(8'h40);
    frame(16'h0001);
    frame(16'h0086);
    step(2);
    chk_sw(8'h40);
    $display("test pwm and leg done");
  endtask
  task automatic test_overcurrent();
    frame(16'h0080);
    overcurrent <= 8'h40;
    step(6);
    overcurrent <= 8'h00;
    chk_sw(8'h00);
    step(40);
    chk_sw(8'h00);
    frame(16'h0201);
    chk(rx, 16'h0080);
    step(40);
    chk_sw(8'h40);
    $display("test overcurrent done");
  endtask
  task automatic test_open_load();
    frame(16'h4080);
    low_current <= 8'h40;
    step(40);
    frame(16'h0001);
    chk(rx, 16'h0001);
    frame(16'h0001);
    chk(rx, 16'h8081);
    frame(16'h0080);
    step(40);
    frame(16'h0001);
    chk(rx, 16'h0000);
    low_current <= 8'h00;
    $display("test open load done");
  endtask
  initial begin
    step(2);
    rst <= 1'b0;
    step(4);
    test_startup();
    test_pwm_leg();
    test_overcurrent();
    test_open_load();
    summarize();
  end
endmodule
`default_nettype wire
